// File: src/tpw_timebase.sv
// Two 8-bit period timers with a shared quarter-cycle phase counter.
// Assumes period values come from software registers on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module tpw_timebase
	import tpw_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [7:0] period_reg_a,
	input  wire logic [7:0] period_reg_b,
	input  wire logic       cascade_req,
	input  wire logic       any_out_used,
	output logic            timer_a_flag,
	output logic            timer_b_flag,
	input  wire logic       clear_flag_a,
	input  wire logic       clear_flag_b,
	output logic            cascaded,
	tpw_tick_if.src         tick
);
	logic [1:0] phase_reg;
	logic [7:0] timer_a_reg;
	logic [7:0] timer_b_reg;
	logic       wrap;
	logic       hit_a;
	logic       hit_b;
	logic       casc_ok;

	assign wrap    = (phase_reg == TPW_PHASE_LAST);
	assign casc_ok = cascade_req && !any_out_used; // R04
	assign hit_a   = wrap && (timer_a_reg == period_reg_a); // R14
	assign hit_b   = casc_ok ? (hit_a && timer_b_reg == period_reg_b)
	                         : (wrap && timer_b_reg == period_reg_b);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			phase_reg <= TPW_PHASE_RESET;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end

	// Period is (period + 1) times four oscillator periods, or (period + 1) timer a periods for cascaded timer b
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			timer_a_reg <= TPW_TIMER_RESET;
			timer_b_reg <= TPW_TIMER_RESET;
		end else begin
			if (hit_a) begin
				timer_a_reg <= TPW_TIMER_RESET; // R14
			end else if (wrap) begin
				timer_a_reg <= timer_a_reg + 8'h01; // R01
			end
			if (hit_b) begin
				timer_b_reg <= TPW_TIMER_RESET;
			end else if (casc_ok ? hit_a : wrap) begin
				timer_b_reg <= timer_b_reg + 8'h01;
			end
		end
	end

	// Set wins over clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			timer_a_flag <= 1'b0;
			timer_b_flag <= 1'b0;
		end else begin
			timer_a_flag <= hit_a | (timer_a_flag & ~clear_flag_a); // R15
			timer_b_flag <= hit_b | (timer_b_flag & ~clear_flag_b); // R15
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cascaded <= 1'b0;
		end else begin
			cascaded <= casc_ok;
		end
	end

	always_comb begin
		tick.phase    = phase_reg;
		tick.count_a  = timer_a_reg;
		tick.count_b  = timer_b_reg;
		tick.period_a = period_reg_a;
		tick.period_b = period_reg_b;
		tick.start_a  = hit_a;
		tick.start_b  = hit_b && !casc_ok;
	end
endmodule
`default_nettype wire

// File: src/tpw_pkg.sv
// Shared constants and types of the triple pulse-width block.
// Assumes one clock domain; timers and software bus are on that clock.
//
// Function
// R01: Output a periods from timer_a and period_reg_a
// R02: Output b timebase selected by bit 5
// R03: Output c timebase selected by bit 5
// R04: No timer cascading while any output used
// R05: Duty is high byte plus low bits 7:6
// R06: Output high for duty times osc period
// R07: Zero duty keeps output low all period
// R08: Duty high equals period: short low end
// R09: Full duty when duty high exceeds period
// R10: Writes land in master latches only
// R11: Period start copies masters, forces output high
// R12: Reads return slave latch contents
// R13: Software avoids read-modify-write on duty registers
// R14: Timer matches period, then rolls to zero
// R15: Timer period events latch into sticky flags
// R16: Compare duty against count joined with phase
package tpw_pkg;
	localparam int TPW_NUM_OUT       = 3;
	localparam int TPW_DUTY_W        = 10;
	localparam int TPW_TIMEBASE_BIT  = 5;
	localparam int TPW_DUTY_LO_MSB   = 7;
	localparam int TPW_DUTY_LO_LSB   = 6;
	localparam logic [7:0] TPW_BYTE_RESET  = 8'h00;
	localparam logic [1:0] TPW_PHASE_RESET = 2'h0;
	localparam logic [1:0] TPW_PHASE_LAST  = 2'h3;
	localparam logic [7:0] TPW_TIMER_RESET = 8'h00;
	localparam logic [7:0] TPW_PERIOD_RESET = 8'hFF;
	typedef enum {TPW_SRC_A, TPW_SRC_B} tpw_src_t;
endpackage

// File: src/tpw_tick_if.sv
// Carries the shared timebase state from the timers to the pulse channels.
// Assumes every party runs on clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface tpw_tick_if;
	logic [1:0] phase;
	logic [7:0] count_a;
	logic [7:0] count_b;
	logic [7:0] period_a;
	logic [7:0] period_b;
	logic       start_a;
	logic       start_b;
	modport src (output phase, count_a, count_b, period_a, period_b, start_a, start_b);
	modport dst (input  phase, count_a, count_b, period_a, period_b, start_a, start_b);
endinterface
`default_nettype wire

// File: src/tpw_channel.sv
// One pulse channel: master/slave duty latches and the output comparator.
// Assumes the timebase interface is driven on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module tpw_channel
	import tpw_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       fixed_a,
	input  wire logic       wr_high,
	input  wire logic       wr_low,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_high,
	output logic      [7:0] rd_low,
	output logic            pulse_out,
	tpw_tick_if.dst         tick
);
	logic [7:0] master_high_reg;
	logic [7:0] master_low_reg;
	logic [7:0] slave_high_reg;
	logic [7:0] slave_low_reg;
	logic       pulse_reg;
	tpw_src_t   src;
	logic       start;
	logic [7:0] count;
	logic [7:0] period;
	logic [TPW_DUTY_W-1:0] duty_value;
	logic [TPW_DUTY_W-1:0] now;
	logic [TPW_DUTY_W-1:0] next_now;

	always_comb begin
		src    = (!fixed_a && slave_low_reg[TPW_TIMEBASE_BIT]) ? TPW_SRC_B : TPW_SRC_A; // R02 R03
		start  = (src == TPW_SRC_B) ? tick.start_b : tick.start_a;
		count  = (src == TPW_SRC_B) ? tick.count_b : tick.count_a;
		period = (src == TPW_SRC_B) ? tick.period_b : tick.period_a;
	end

	assign duty_value = {slave_high_reg, slave_low_reg[TPW_DUTY_LO_MSB:TPW_DUTY_LO_LSB]}; // R05
	assign now        = {count, tick.phase}; // R16
	assign next_now   = now + 10'h001;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			master_high_reg <= TPW_BYTE_RESET;
			master_low_reg  <= TPW_BYTE_RESET;
		end else begin
			if (wr_high) begin
				master_high_reg <= wr_data; // R10
			end
			if (wr_low) begin
				master_low_reg <= wr_data; // R10
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			slave_high_reg <= TPW_BYTE_RESET;
			slave_low_reg  <= TPW_BYTE_RESET;
		end else if (start) begin
			slave_high_reg <= master_high_reg; // R11
			slave_low_reg  <= master_low_reg; // R11
		end
	end

	// Low when the next phase reaches duty; duty above period never matches
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pulse_reg <= 1'b0;
		end else if (start) begin
			pulse_reg <= (master_high_reg != 8'h00) || (master_low_reg[7:6] != 2'h0); // R11 R07
		end else if (slave_high_reg > period) begin
			pulse_reg <= 1'b1; // R09
		end else if (next_now >= duty_value) begin
			pulse_reg <= 1'b0; // R06 R08 R16
		end
	end

	assign rd_high   = slave_high_reg; // R12
	assign rd_low    = slave_low_reg; // R12
	assign pulse_out = pulse_reg;
endmodule
`default_nettype wire

// File: src/tpw_top.sv
// Top of the triple pulse-width block: timers plus three channels.
// Assumes software strobes and data arrive synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module tpw_top
	import tpw_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [7:0] period_reg_a,
	input  wire logic [7:0] period_reg_b,
	input  wire logic       cascade_req,
	input  wire logic [2:0] out_enable,
	input  wire logic [2:0] wr_high,
	input  wire logic [2:0] wr_low,
	input  wire logic [7:0] wr_data,
	output logic      [23:0] rd_high,
	output logic      [23:0] rd_low,
	input  wire logic       clear_flag_a,
	input  wire logic       clear_flag_b,
	output logic            timer_a_flag,
	output logic            timer_b_flag,
	output logic            cascaded,
	output logic            pulse_out_a,
	output logic            pulse_out_b,
	output logic            pulse_out_c
);
	tpw_tick_if tick ();
	logic [2:0] pulses;

	tpw_timebase u_timebase (
		.clk_sys      (clk_sys),
		.reset        (reset),
		.period_reg_a (period_reg_a),
		.period_reg_b (period_reg_b),
		.cascade_req  (cascade_req),
		.any_out_used (|out_enable), // R04
		.timer_a_flag (timer_a_flag),
		.timer_b_flag (timer_b_flag),
		.clear_flag_a (clear_flag_a),
		.clear_flag_b (clear_flag_b),
		.cascaded     (cascaded),
		.tick         (tick.src)
	);

	genvar gi;
	generate
		for (gi = 0; gi < TPW_NUM_OUT; gi++) begin : g_ch
			logic raw;
			tpw_channel u_ch (
				.clk_sys   (clk_sys),
				.reset     (reset),
				.fixed_a   (gi == 0), // R01
				.wr_high   (wr_high[gi]),
				.wr_low    (wr_low[gi]),
				.wr_data   (wr_data),
				.rd_high   (rd_high[gi*8 +: 8]),
				.rd_low    (rd_low[gi*8 +: 8]),
				.pulse_out (raw),
				.tick      (tick.dst)
			);
			assign pulses[gi] = raw & out_enable[gi];
		end
	endgenerate

	assign pulse_out_a = pulses[0];
	assign pulse_out_b = pulses[1];
	assign pulse_out_c = pulses[2];
endmodule
`default_nettype wire

// File: test/tpw_monitor.sv
// Concurrent checks on the pulse-width top, watched through channel a.
// Assumes period_reg_a and out_enable[0] stay steady while a runs.
`timescale 1ns/100ps
`default_nettype none
module tpw_monitor (
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic [7:0]  period_reg_a,
	input wire logic [2:0]  out_enable,
	input wire logic [23:0] rd_high,
	input wire logic [23:0] rd_low,
	input wire logic        clear_flag_a,
	input wire logic        clear_flag_b,
	input wire logic        timer_a_flag,
	input wire logic        timer_b_flag,
	input wire logic        cascaded,
	input wire logic        pulse_out_a
);
	logic        prev_reg;
	logic        seen_reg;
	logic [15:0] hcnt_reg;
	logic [15:0] pcnt_reg;
	wire  [9:0]  duty = {rd_high[7:0], rd_low[7:6]};
	wire         rise = pulse_out_a & ~prev_reg;
	// High time and rise-to-rise distance of channel a
	always_ff @(posedge clk_sys) begin
		prev_reg <= reset ? 1'b0 : pulse_out_a;
		seen_reg <= reset ? 1'b0 : seen_reg | rise;
		hcnt_reg <= pulse_out_a ? hcnt_reg + 16'h0001 : 16'h0000;
		pcnt_reg <= rise ? 16'h0001 : pcnt_reg + 16'h0001;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// A fall that ends a full-duty run spans more than one period
	a_high_time: assert property ($fell(pulse_out_a) && out_enable[0]
		&& hcnt_reg <= 16'(period_reg_a) * 16'h0004 + 16'h0004 |-> hcnt_reg == {6'h00, duty})
		else $error("high time differs from duty");
	a_period_len: assert property (rise && seen_reg |-> pcnt_reg % (16'(period_reg_a) * 16'h0004 + 16'h0004) == 16'h0000)
		else $error("period start off the timebase");
	a_zero_duty: assert property (duty == 10'h000 && $past(duty) == 10'h000 |-> !pulse_out_a)
		else $error("output high at zero duty");
	a_full_duty: assert property (out_enable[0] && rd_high[7:0] > period_reg_a && $stable(rd_high[7:0]) |-> pulse_out_a)
		else $error("output low at full duty");
	a_cascade_off: assert property (|out_enable && $past(|out_enable) |-> !cascaded)
		else $error("cascade while outputs in use");
	a_flag_a_hold: assert property (timer_a_flag && !clear_flag_a |=> timer_a_flag)
		else $error("flag a dropped without clear");
	a_flag_b_hold: assert property (timer_b_flag && !clear_flag_b |=> timer_b_flag)
		else $error("flag b dropped without clear");
	a_slave_load: assert property (!$stable(rd_high[7:0]) && duty != 10'h000 && out_enable[0] |-> ##[0:1] rise)
		else $error("duty reload away from period start");
	c_fall: cover property ($fell(pulse_out_a));
	c_period: cover property (rise && seen_reg);
	c_cascade: cover property ($rose(cascaded));
endmodule
bind tpw_top tpw_monitor tpw_monitor_inst (.clk_sys, .reset, .period_reg_a, .out_enable, .rd_high, .rd_low,
	.clear_flag_a, .clear_flag_b, .timer_a_flag, .timer_b_flag, .cascaded, .pulse_out_a);
`default_nettype wire

// File: test/tpw_top_tb.sv
// Directed bench for the triple pulse-width top.
// Assumes a 10 MHz clock; inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
module tpw_top_tb;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  period_reg_a = 8'h03;
	logic [7:0]  period_reg_b = 8'h01;
	logic        cascade_req = 1'b0;
	logic [2:0]  out_enable = 3'h7;
	logic [2:0]  wr_high = 3'h0;
	logic [2:0]  wr_low = 3'h0;
	logic [7:0]  wr_data = 8'h00;
	logic        clear_flag_a = 1'b0;
	logic        clear_flag_b = 1'b0;
	wire  [23:0] rd_high, rd_low;
	wire         timer_a_flag, timer_b_flag, cascaded, pulse_out_a, pulse_out_b, pulse_out_c;
	wire  [2:0]  pulse = {pulse_out_c, pulse_out_b, pulse_out_a};
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycle_count = 0;
	int          hi, per, i;
	tpw_top tpw_top_inst (.clk_sys, .reset, .period_reg_a, .period_reg_b, .cascade_req, .out_enable, .wr_high,
		.wr_low, .wr_data, .rd_high, .rd_low, .clear_flag_a, .clear_flag_b, .timer_a_flag, .timer_b_flag,
		.cascaded, .pulse_out_a, .pulse_out_b, .pulse_out_c);
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycle_count++;
		if (cycle_count == 3000) begin
			mismatches++;
			test_done;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		num_checks++;
		if (exp !== got) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// Whole values only, never read back and modified
	task automatic wr(input int ch, input logic [7:0] h, input logic [7:0] l);
		wr_high[ch] = 1'b1;
		wr_data = h;
		tick(1);
		wr_high[ch] = 1'b0;
		wr_low[ch] = 1'b1;
		wr_data = l;
		tick(1);
		wr_low[ch] = 1'b0;
	endtask
	task automatic run(input int s, input logic lvl, inout int n);
		while (pulse[s] === lvl && n < 60) begin
			tick(1);
			n++;
		end
	endtask
	// Skips the period under way, then times the next high phase and period
	task automatic meas(input int s);
		i = 0;
		run(s, 1'b1, i);
		run(s, 1'b0, i);
		hi = 0;
		run(s, 1'b1, hi);
		per = hi;
		run(s, 1'b0, per);
	endtask
	task automatic held(input string what, input int exp);
		tick(20);
		hi = 0;
		repeat (16) begin
			tick(1);
			hi += pulse_out_a;
		end
		chk(what, 24'(exp), 24'(hi));
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		tick(5);
		reset = 1'b0;
		chk("pulses", 24'h00_0000, {21'h00_0000, pulse});
		wr(0, 8'h02, 8'h80);
		meas(0);
		chk("high a", 24'h00_000a, 24'(hi));
		chk("period a", 24'h00_0010, 24'(per));
		chk("duty a", 24'h00_000a, {14'h0000, rd_high[7:0], rd_low[7:6]});
		wr(0, 8'h03, 8'h40);
		chk("duty a", 24'h00_000a, {14'h0000, rd_high[7:0], rd_low[7:6]});
		meas(0);
		chk("high a", 24'h00_000d, 24'(hi));
		chk("duty a", 24'h00_000d, {14'h0000, rd_high[7:0], rd_low[7:6]});
		wr(0, 8'h04, 8'h00);
		held("full", 16);
		wr(0, 8'h00, 8'h00);
		held("zero", 0);
		wr(0, 8'h02, 8'h80);
		for (int c = 1; c < 3; c++) begin
			for (int s = 0; s < 2; s++) begin
				wr(c, 8'h01, s ? 8'h20 : 8'h00);
				meas(c);
				meas(c);
				chk("duty bc", {8'h00, 8'h01, s ? 8'h20 : 8'h00}, {8'h00, rd_high[c*8 +: 8], rd_low[c*8 +: 8]});
				chk("high bc", 24'h00_0004, 24'(hi));
				chk("period bc", s ? 24'h00_0008 : 24'h00_0010, 24'(per));
			end
		end
		i = 0;
		run(0, 1'b1, i);
		run(0, 1'b0, i);
		tick(2);
		clear_flag_a = 1'b1;
		clear_flag_b = 1'b1;
		tick(1);
		clear_flag_a = 1'b0;
		clear_flag_b = 1'b0;
		chk("flags", 24'h00_0000, {22'h00_0000, timer_b_flag, timer_a_flag});
		tick(16);
		chk("flags", 24'h00_0003, {22'h00_0000, timer_b_flag, timer_a_flag});
		cascade_req = 1'b1;
		tick(3);
		chk("cascade", 24'h00_0000, {23'h00_0000, cascaded});
		out_enable = 3'h0;
		tick(3);
		chk("cascade", 24'h00_0001, {23'h00_0000, cascaded});
		test_done;
	end
endmodule
`default_nettype wire
